//--- tb/pcf_pin_change_bench.sv
// self-checking bench for the pin change flag block
`timescale 1ns/10ps
module pcf_pin_change_bench;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, erv;
    logic [11:0] padr = 12'h000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] pwd = 32'h0, rdv, seed = 32'h0000004E;
    logic [23:0] lvl = 24'h000000, pins;
    wire [31:0] prd;
    wire sum, irq, wake, rdy, err;
    int errors = 0, cmp_count = 0;
    int m[13];
    int mk[3] = '{8'h3F, 8'hF0, 8'hFF};
    pcf_pin_change DUT (.CORE_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(padr), .PWDATA(pwd), .PSTRB(pstrb), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err),
        .PORTA_PIN_N(pins[23:16]), .PORTB_PIN_N(pins[15:8]), .PORTC_PIN_N(pins[7:0]),
        .PIN_CHANGE_SUMMARY_FLAG(sum), .PIN_CHANGE_IRQ(irq), .WAKE(wake));
    pcf_pins PINS (.clk(clk), .lvl(lvl), .pins(pins));
    initial forever #2.5 clk = ~clk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic bit fs();
        return (m[2] | m[5] | m[8]) != 0;
    endfunction
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_out(input logic [2:0] got, input logic [2:0] exp);
        chk({29'h0, got}, {29'h0, exp});
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 16);
        if (rdy !== 1'b1) begin
            errors++;
            stop_test();
        end
        rdv = prd;
        erv = err;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input int i, input int d);
        apb(1'b1, 12'(4 * i), 8'(d));
        if (i == 9) m[9] = d & 1;
        else if (i % 3 == 2) m[i] &= d;
        else if (i < 9) m[i] = d & mk[i / 3];
    endtask
    task automatic rd(input int i);
        int e;
        apb(1'b0, 12'(4 * i), 8'h00);
        e = (i == 10) ? fs() + 2 * (fs() & m[9][0]) : m[i];
        chk(rdv, e);
        chk({31'h0, erv}, i > 10);
    endtask
    task automatic pins_to(input logic [23:0] nv);
        for (int p = 0; p < 3; p++) begin
            int o = lvl[23 - 8 * p -: 8];
            int n = nv[23 - 8 * p -: 8];
            m[3 * p + 2] |= ((n & ~o & m[3 * p]) | (~n & o & m[3 * p + 1])) & mk[p];
        end
        lvl <= nv;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 13; i++) rd(i);
        for (int i = 0; i < 10; i++) wr(i, 8'hFF);
        for (int i = 0; i < 10; i++) rd(i);
        wr(9, 8'h00);
        // a write without byte lane 0 must leave the register as it was
        pstrb <= 4'hE;
        apb(1'b1, 12'h000, 8'h15);
        pstrb <= 4'hF;
        rd(0);
        $display("test registers done");
        for (int k = 0; k < 40; k++) begin
            if (k == 20) wr(9, 8'h01);
            if (k % 4 == 0) for (int i = 0; i < 9; i++) if (i % 3 != 2) wr(i, xs());
            pins_to(24'(xs()));
            repeat (6) @(posedge clk);
            chk_out({sum, irq, wake}, {fs(), {2{fs() & m[9][0]}}});
            rd(2 + 3 * (k % 3));
            if (k % 5 == 4) wr(2 + 3 * (k % 3), rdv ^ 8'hFF);
            rd(2 + 3 * (k % 3));
        end
        $display("test edges done");
        wr(0, 8'h01);
        pins_to(lvl & 24'h00FFFF);
        repeat (6) @(posedge clk);
        wr(2, 8'h00);
        pins_to(lvl | 24'h010000);
        repeat (2) @(posedge clk);
        apb(1'b1, 12'h008, 8'h00);
        repeat (6) @(posedge clk);
        rd(2);
        $display("test clear race done");
        stop_test();
    end
endmodule // pcf_pin_change_bench

//--- tb/pcf_pin_change_monitor.sv
// assertion checker for the pin change flag block
`timescale 1ns/10ps
module pcf_mon (
    input wire CORE_CLK,
    input wire RESET,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [3:0] PSTRB,
    input wire [31:0] PRDATA,
    input wire PREADY,
    input wire PSLVERR,
    input wire [7:0] PORTA_PIN_N,
    input wire [7:0] PORTB_PIN_N,
    input wire [7:0] PORTC_PIN_N,
    input wire PIN_CHANGE_SUMMARY_FLAG,
    input wire PIN_CHANGE_IRQ,
    input wire WAKE
);
    wire acc = PSEL & PENABLE & PREADY;
    wire rd = acc & !PWRITE;
    wire fad = PADDR == 12'h008 | PADDR == 12'h014 | PADDR == 12'h020;
    wire fwr = acc & PWRITE & fad;
    wire [23:0] pins = {PORTA_PIN_N, PORTB_PIN_N, PORTC_PIN_N};
    reg en_r;
    reg [2:0] q_r;
    reg [23:0] pins_d_r;
    // tracks the irq enable and the cycles since the last pin change
    always @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            en_r <= 1'b0;
            q_r <= 3'h0;
            pins_d_r <= 24'h000000;
        end else begin
            if (acc & PWRITE & PSTRB[0] & PADDR == 12'h024) begin
                en_r <= PWDATA[0];
            end
            q_r <= (pins_d_r != pins) ? 3'h0 : q_r + {2'h0, q_r != 3'h7};
            pins_d_r <= pins;
        end
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    property p_irq; PIN_CHANGE_IRQ == (PIN_CHANGE_SUMMARY_FLAG & $past(en_r)); endproperty
    a_irq: assert property (p_irq) else $error("irq wrong");
    property p_wake; WAKE == PIN_CHANGE_IRQ; endproperty
    a_wake: assert property (p_wake) else $error("wake wrong");
    property p_cause; $rose(PIN_CHANGE_SUMMARY_FLAG) |-> q_r <= 3'h4; endproperty
    a_cause: assert property (p_cause) else $error("flag without edge");
    property p_clr; $fell(PIN_CHANGE_SUMMARY_FLAG) |-> $past(fwr, 2); endproperty
    a_clr: assert property (p_clr) else $error("flag lost");
    property p_sum; rd && fad && PRDATA[7:0] != 8'h00 |-> ##[0:1] PIN_CHANGE_SUMMARY_FLAG; endproperty
    a_sum: assert property (p_sum) else $error("summary low");
    property p_pa; rd && PADDR < 12'h00C |-> PRDATA[31:6] == 26'h0; endproperty
    a_pa: assert property (p_pa) else $error("port a bits");
    property p_pb; rd && PADDR >= 12'h00C && PADDR < 12'h018 |-> PRDATA[31:8] == 24'h0
        && PRDATA[3:0] == 4'h0; endproperty
    a_pb: assert property (p_pb) else $error("port b bits");
    property p_pc; rd && PADDR >= 12'h018 && PADDR < 12'h024 |-> PRDATA[31:8] == 24'h0; endproperty
    a_pc: assert property (p_pc) else $error("port c bits");
    cover property ($rose(PIN_CHANGE_IRQ));
    cover property ($fell(PIN_CHANGE_SUMMARY_FLAG));
    cover property (PSLVERR);
endmodule // pcf_mon
bind pcf_pin_change pcf_mon u_mon (.*);

//--- tb/pcf_pin_model.sv
// external pin drivers: levels reach the pins one clock after the request
`timescale 1ns/10ps
module pcf_pins (
    input wire clk,
    input wire [23:0] lvl,
    output logic [23:0] pins = 24'h000000
);
    always @(posedge clk) begin
        pins <= lvl;
    end
endmodule // pcf_pins

//--- verilog/pcf_consts.vh
// register offsets, field layouts and reset values of the pin change flag block
`ifndef PCF_CONSTS_VH
`define PCF_CONSTS_VH

`define PCF_OFF_PA_RISE 12'h000
`define PCF_OFF_PA_FALL 12'h004
`define PCF_OFF_PA_FLAG 12'h008
`define PCF_OFF_PB_RISE 12'h00C
`define PCF_OFF_PB_FALL 12'h010
`define PCF_OFF_PB_FLAG 12'h014
`define PCF_OFF_PC_RISE 12'h018
`define PCF_OFF_PC_FALL 12'h01C
`define PCF_OFF_PC_FLAG 12'h020
`define PCF_OFF_CTRL 12'h024
`define PCF_OFF_STATUS 12'h028

`define PCF_PA_MASK 8'h3F
`define PCF_PB_MASK 8'hF0
`define PCF_PC_MASK 8'hFF
`define PCF_CTRL_IRQ_EN_BIT 0
`define PCF_STAT_SUMMARY_BIT 0
`define PCF_STAT_WAKE_BIT 1
`define PCF_RESET_BYTE 8'h00
`define PCF_PIN_COUNT 24

`endif

//--- verilog/pcf_flag_bit.v
// one pin change flag: enabled edges set it, software clears it by writing zero
`timescale 1ns/10ps
module pcf_flag_bit (
    input wire clk,
    input wire rst,
    input wire rise,
    input wire fall,
    input wire rise_en,
    input wire fall_en,
    input wire wr,
    input wire wr_data,
    output reg flag_r
);
    wire hit;
    assign hit = (rise & rise_en) | (fall & fall_en);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_r <= 1'b0;
        end else if (hit) begin
            flag_r <= 1'b1;
        end else if (wr && !wr_data) begin
            flag_r <= 1'b0;
        end
    end
endmodule // pcf_flag_bit

//--- verilog/pcf_pin_change.v
// pin change flag block: edge enables, per-pin flags, summary and wake, on APB
//
// Contract
// - enabled edge sets that pin's flag
// - request raised only when module enable set
// - summary flag is OR of all flags
// - writing zero clears a flag bit
// - edge during clear write leaves flag set
// - pin change wakes from sleep when enabled
// - sleep edges recorded before first instruction
// - port A rise enables bits 5-0
// - port A fall enables bits 5-0
// - flag set by enabled rise or fall
// - port B enables bits 7-4 only
// - port B flags bits 7-4 only
// - both enables flag either edge direction
// - detection continues with module enable clear
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`include "pcf_consts.vh"
module pcf_pin_change (
    input wire CORE_CLK,
    input wire RESET,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [3:0] PSTRB,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire [7:0] PORTA_PIN_N,
    input wire [7:0] PORTB_PIN_N,
    input wire [7:0] PORTC_PIN_N,
    output reg PIN_CHANGE_SUMMARY_FLAG,
    output reg PIN_CHANGE_IRQ,
    output reg WAKE
);
    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    reg [7:0] porta_rise_enable_r;
    reg [7:0] porta_fall_enable_r;
    reg [7:0] portb_rise_enable_r;
    reg [7:0] portb_fall_enable_r;
    reg [7:0] portc_rise_enable_r;
    reg [7:0] portc_fall_enable_r;
    reg pin_change_irq_enable_r;

    wire [23:0] rise;
    wire [23:0] fall;
    wire [23:0] flags;
    wire [23:0] rise_en;
    wire [23:0] fall_en;
    wire [23:0] flag_wr;
    wire [23:0] pin_bus;
    wire [23:0] impl_mask;

    wire setup;
    wire wr_en;
    wire rd_en;
    reg [31:0] rdata_nxt;
    reg mapped_nxt;

    assign setup = PSEL & ~PENABLE;
    assign wr_en = PSEL & PENABLE & PWRITE & PREADY & PSTRB[0];
    assign rd_en = setup & ~PWRITE;

    assign pin_bus = {PORTC_PIN_N, PORTB_PIN_N, PORTA_PIN_N};
    assign impl_mask = {`PCF_PC_MASK, `PCF_PB_MASK, `PCF_PA_MASK};

    ////////////////////////////////////////////////////////////////////////
    // edge detection runs regardless of the module enable
    pcf_sync_edge #(
        .WIDTH(`PCF_PIN_COUNT)
    ) u_sync (
        .clk(CORE_CLK),
        .rst(RESET),
        .pin_async(pin_bus),
        .rise(rise),
        .fall(fall)
    );

    assign rise_en = {portc_rise_enable_r, portb_rise_enable_r, porta_rise_enable_r};
    assign fall_en = {portc_fall_enable_r, portb_fall_enable_r, porta_fall_enable_r};
    assign flag_wr[7:0] = (wr_en && PADDR == `PCF_OFF_PA_FLAG) ? 8'hFF : 8'h00;
    assign flag_wr[15:8] = (wr_en && PADDR == `PCF_OFF_PB_FLAG) ? 8'hFF : 8'h00;
    assign flag_wr[23:16] = (wr_en && PADDR == `PCF_OFF_PC_FLAG) ? 8'hFF : 8'h00;

    // implemented pin positions, known at elaboration so unused flags are never built
    localparam [23:0] impl_bits = {`PCF_PC_MASK, `PCF_PB_MASK, `PCF_PA_MASK};

    genvar gi;
    generate
        for (gi = 0; gi < `PCF_PIN_COUNT; gi = gi + 1) begin : g_flag
            if (impl_bits[gi]) begin : g_impl
                pcf_flag_bit u_flag (
                    .clk(CORE_CLK),
                    .rst(RESET),
                    .rise(rise[gi]),
                    .fall(fall[gi]),
                    .rise_en(rise_en[gi]),
                    .fall_en(fall_en[gi]),
                    .wr(flag_wr[gi]),
                    .wr_data(PWDATA[gi % 8]),
                    .flag_r(flags[gi])
                );
            end else begin : g_none
                assign flags[gi] = 1'b0;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // register writes; unimplemented bits never store
    always @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            porta_rise_enable_r <= `PCF_RESET_BYTE;
            porta_fall_enable_r <= `PCF_RESET_BYTE;
            portb_rise_enable_r <= `PCF_RESET_BYTE;
            portb_fall_enable_r <= `PCF_RESET_BYTE;
            portc_rise_enable_r <= `PCF_RESET_BYTE;
            portc_fall_enable_r <= `PCF_RESET_BYTE;
            pin_change_irq_enable_r <= 1'b0;
        end else if (wr_en) begin
            case (PADDR)
                `PCF_OFF_PA_RISE: porta_rise_enable_r <= PWDATA[7:0] & `PCF_PA_MASK;
                `PCF_OFF_PA_FALL: porta_fall_enable_r <= PWDATA[7:0] & `PCF_PA_MASK;
                `PCF_OFF_PB_RISE: portb_rise_enable_r <= PWDATA[7:0] & `PCF_PB_MASK;
                `PCF_OFF_PB_FALL: portb_fall_enable_r <= PWDATA[7:0] & `PCF_PB_MASK;
                `PCF_OFF_PC_RISE: portc_rise_enable_r <= PWDATA[7:0] & `PCF_PC_MASK;
                `PCF_OFF_PC_FALL: portc_fall_enable_r <= PWDATA[7:0] & `PCF_PC_MASK;
                `PCF_OFF_CTRL: pin_change_irq_enable_r <= PWDATA[`PCF_CTRL_IRQ_EN_BIT];
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux
    always @* begin
        rdata_nxt = 32'h00000000;
        mapped_nxt = 1'b1;
        case (PADDR)
            `PCF_OFF_PA_RISE: rdata_nxt[7:0] = porta_rise_enable_r;
            `PCF_OFF_PA_FALL: rdata_nxt[7:0] = porta_fall_enable_r;
            `PCF_OFF_PA_FLAG: rdata_nxt[7:0] = flags[7:0];
            `PCF_OFF_PB_RISE: rdata_nxt[7:0] = portb_rise_enable_r;
            `PCF_OFF_PB_FALL: rdata_nxt[7:0] = portb_fall_enable_r;
            `PCF_OFF_PB_FLAG: rdata_nxt[7:0] = flags[15:8];
            `PCF_OFF_PC_RISE: rdata_nxt[7:0] = portc_rise_enable_r;
            `PCF_OFF_PC_FALL: rdata_nxt[7:0] = portc_fall_enable_r;
            `PCF_OFF_PC_FLAG: rdata_nxt[7:0] = flags[23:16];
            `PCF_OFF_CTRL: rdata_nxt[`PCF_CTRL_IRQ_EN_BIT] = pin_change_irq_enable_r;
            `PCF_OFF_STATUS: begin
                rdata_nxt[`PCF_STAT_SUMMARY_BIT] = PIN_CHANGE_SUMMARY_FLAG;
                rdata_nxt[`PCF_STAT_WAKE_BIT] = WAKE;
            end
            default: mapped_nxt = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // apb answer: ready in the first access cycle, error on unmapped address
    always @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            PRDATA <= 32'h00000000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= setup;
            PSLVERR <= setup & ~mapped_nxt;
            if (rd_en) begin
                PRDATA <= rdata_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // summary, request and wake follow flags one cycle later, so a flag is
    // visible to software before the core can run after waking
    always @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            PIN_CHANGE_SUMMARY_FLAG <= 1'b0;
            PIN_CHANGE_IRQ <= 1'b0;
            WAKE <= 1'b0;
        end else begin
            PIN_CHANGE_SUMMARY_FLAG <= |(flags & impl_mask);
            PIN_CHANGE_IRQ <= (|flags) & pin_change_irq_enable_r;
            WAKE <= (|flags) & pin_change_irq_enable_r;
        end
    end
endmodule // pcf_pin_change

//--- verilog/pcf_sync_edge.v
// two-stage pin synchroniser with rising and falling edge pulses
`timescale 1ns/10ps
module pcf_sync_edge #(
    parameter WIDTH = 24
) (
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] pin_async,
    output wire [WIDTH-1:0] rise,
    output wire [WIDTH-1:0] fall
);
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;
    reg [WIDTH-1:0] prev_r;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= {WIDTH{1'b0}};
            sync_r <= {WIDTH{1'b0}};
            prev_r <= {WIDTH{1'b0}};
        end else begin
            meta_r <= pin_async;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign rise = sync_r & ~prev_r;
    assign fall = ~sync_r & prev_r;
endmodule // pcf_sync_edge
